// File: route_defs.svh
// Constants for the pin output routing selectors and their controller
`ifndef ROUTE_DEFS_SVH
`define ROUTE_DEFS_SVH

// Selector block placement and geometry
`define ROUTE_BASE_ADDR   32'h40040800
`define ROUTE_NUM_PINS    45
`define ROUTE_OFF_W       7
`define ROUTE_SEL_W       4
`define ROUTE_REG_W       8
`define ROUTE_SEL_RESET   4'h0

// Byte offsets of the selectors, pin index 0 in the lowest slice
`define ROUTE_OFFSETS {7'h57, 7'h56, 7'h50, 7'h4f, 7'h4e, 7'h48, 7'h44, 7'h43, \
  7'h42, 7'h41, 7'h40, 7'h3d, 7'h3c, 7'h3b, 7'h3a, 7'h39, 7'h38, 7'h33, 7'h32, \
  7'h31, 7'h30, 7'h29, 7'h28, 7'h21, 7'h20, 7'h19, 7'h18, 7'h17, 7'h16, 7'h15, \
  7'h14, 7'h13, 7'h12, 7'h11, 7'h10, 7'h0f, 7'h0e, 7'h0d, 7'h0c, 7'h0b, 7'h0a, \
  7'h09, 7'h08, 7'h01, 7'h00}

// Selector codes
`define CODE_DEFAULT      4'h0
`define CODE_LAST         4'ha
`define ROUTE_NUM_SRC     10

// Controller register offsets on AXI4-Lite
`define CTRL_AW           8
`define CTRL_CMD_OFF      8'h00
`define CTRL_STAT_OFF     8'h04

// Command register fields
`define CMD_DATA_LSB      0
`define CMD_OFF_LSB       8
`define CMD_WE_BIT        16

// Status register fields
`define ST_BUSY_BIT       0
`define ST_DONE_BIT       1
`define ST_ERR_BIT        2
`define ST_DATA_LSB       8

// AXI responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// File: route_pkg.sv
// Types shared by the routing device and its controller
`include "route_defs.svh"
package route_pkg;

  // Controller link state, one-hot
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b01,
    LINK_WAIT = 2'b10
  } link_state_t;

  // Whole state of the routing device
  typedef struct packed {
    logic [`ROUTE_NUM_PINS-1:0][`ROUTE_SEL_W-1:0] sel;
    logic                                         ack;
    logic                                         err;
    logic [`ROUTE_REG_W-1:0]                      rdata;
    logic [`ROUTE_NUM_PINS-1:0]                   level;
    logic [`ROUTE_NUM_PINS-1:0]                   drive_en;
    logic [`ROUTE_NUM_PINS-1:0]                   routed;
    logic [`ROUTE_NUM_PINS-1:0]                   bad;
  } route_state_t;

  // Whole state of the controller
  typedef struct packed {
    link_state_t             link;
    logic                    req;
    logic                    we;
    logic [`ROUTE_OFF_W-1:0] addr;
    logic [`ROUTE_REG_W-1:0] wdata;
    logic                    done;
    logic                    err;
    logic [`ROUTE_REG_W-1:0] rdata;
    logic                    awready;
    logic                    wready;
    logic                    aw_held;
    logic                    w_held;
    logic [`CTRL_AW-1:0]     awaddr;
    logic [31:0]             wd;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata_ax;
    logic [1:0]              rresp;
  } ctrl_state_t;

endpackage

// File: route_if.sv
// Register access link between controller and routing device
`timescale 1ns/1ps
`include "route_defs.svh"
interface route_if;
  logic                    req;
  logic                    we;
  logic [`ROUTE_OFF_W-1:0] addr;
  logic [`ROUTE_REG_W-1:0] wdata;
  logic                    ack;
  logic                    err;
  logic [`ROUTE_REG_W-1:0] rdata;

  // Device end answers requests
  modport device (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output err,
    output rdata
  );

  // Controller end issues requests
  modport ctrl (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  err,
    input  rdata
  );
endinterface

// File: pin_route_mux.sv
// One pin's output selection and pad drive decision
`timescale 1ns/1ps
`include "route_defs.svh"
module pin_route_mux (
  // Selector and sources
  input  wire logic [`ROUTE_SEL_W-1:0]   sel,
  input  wire logic [`ROUTE_NUM_SRC-1:0] src,
  input  wire logic                      fixed_level,
  // Pin mode inputs
  input  wire logic                      analog,
  input  wire logic                      dir_in,
  input  wire logic                      open_drain,
  // Results
  output logic                           level,
  output logic                           drive_en,
  output logic                           routed,
  output logic                           bad
);

  // Pick the source; forbidden codes fall back to the fixed function
  always_comb begin
    routed = (sel != `CODE_DEFAULT) && (sel <= `CODE_LAST);
    bad    = (sel > `CODE_LAST);
    if (analog) begin
      level = 1'b0;
    end else if (routed) begin
      level = src[sel - 4'h1];
    end else begin
      level = fixed_level;
    end
    // Open drain only pulls low; analog and input pins stay released
    drive_en = !analog && !dir_in && (!open_drain || !level);
  end

endmodule

// File: route_device.sv
// Per-pin output routing selectors with their pad multiplexers
//
// Function
// - Selectors clear to zero on reset
// - Each pin selector at own byte offset
// - Code zero keeps default function or GPIO
// - Codes one to four route timer channels
// - Codes five, six route serial data/UART
// - Codes seven to ten: buzzer, clocks, UART1
// - Software never writes codes eleven to fifteen (device stores them, leaves the pin unrouted, sets pin_bad_code)
// - Only fifteen listed outputs are relocatable
// - Analog use keeps selector zero, analog set
// - GPIO keeps selector zero, latch drives level
// - Timer/buzzer routing clears pin mode bits
// - Serial/UART routing sets output latch high
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "route_defs.svh"
module route_device #(
  parameter int N = `ROUTE_NUM_PINS
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Register access link
  route_if.device           bus,
  // Relocatable peripheral outputs
  input  wire logic         timer1_channel0_out,
  input  wire logic         timer1_channel1_out,
  input  wire logic         timer1_channel2_out,
  input  wire logic         timer1_channel3_out,
  input  wire logic         serial_ch0_data_out,
  input  wire logic         serial_ch2_data_out,
  input  wire logic         buzzer_clock_zero_out,
  input  wire logic         serial_ch0_clock_out,
  input  wire logic         serial_ch2_clock_out,
  input  wire logic         uart_one_transmit,
  // Per-pin mode bits and fixed function level
  input  wire logic [N-1:0] pin_analog_select_bit,
  input  wire logic [N-1:0] pin_direction_bit,
  input  wire logic [N-1:0] pin_open_drain_bit,
  input  wire logic [N-1:0] fixed_out,
  // Pad drive and routing status
  output logic      [N-1:0] pad_level,
  output logic      [N-1:0] pad_drive_en,
  output logic      [N-1:0] pin_routed,
  output logic      [N-1:0] pin_bad_code
);
  import route_pkg::*;

  // Offset table, pin index 0 in the lowest slice
  localparam logic [N-1:0][`ROUTE_OFF_W-1:0] OFFS = `ROUTE_OFFSETS;

  route_state_t cur;
  route_state_t next_state;

  // Source bus, entry k-1 carries code k; shared outputs already
  // merged inside their peripheral (UART0 with ch0 data, UART2 and
  // infrared with ch2 data, simple I2C clocks with serial clocks)
  // Codes eleven to fifteen have no entry and leave the pin unrouted
  logic [`ROUTE_NUM_SRC-1:0] src;

  // Address decode result; the index means nothing while hit is low
  logic       hit;
  logic [5:0] hit_idx;

  // Combinational pad decisions from every pin mux
  logic [N-1:0] mux_level;
  logic [N-1:0] mux_drive;
  logic [N-1:0] mux_routed;
  logic [N-1:0] mux_bad;

  // Gather the ten source inputs; nothing else may enter
  assign src = {uart_one_transmit,
                serial_ch2_clock_out,
                serial_ch0_clock_out,
                buzzer_clock_zero_out,
                serial_ch2_data_out,
                serial_ch0_data_out,
                timer1_channel3_out,
                timer1_channel2_out,
                timer1_channel1_out,
                timer1_channel0_out};

  // Match the offset against the table; holes in the map miss.
  // Offsets are unique, so the order of the chain sets no priority.
  // A miss leaves every selector untouched and answers with an error.
  always_comb begin
    hit     = 1'b1;
    hit_idx = 6'h00;
    if (bus.addr == OFFS[6'h00]) hit_idx = 6'h00;
    else if (bus.addr == OFFS[6'h01]) hit_idx = 6'h01;
    else if (bus.addr == OFFS[6'h02]) hit_idx = 6'h02;
    else if (bus.addr == OFFS[6'h03]) hit_idx = 6'h03;
    else if (bus.addr == OFFS[6'h04]) hit_idx = 6'h04;
    else if (bus.addr == OFFS[6'h05]) hit_idx = 6'h05;
    else if (bus.addr == OFFS[6'h06]) hit_idx = 6'h06;
    else if (bus.addr == OFFS[6'h07]) hit_idx = 6'h07;
    else if (bus.addr == OFFS[6'h08]) hit_idx = 6'h08;
    else if (bus.addr == OFFS[6'h09]) hit_idx = 6'h09;
    else if (bus.addr == OFFS[6'h0a]) hit_idx = 6'h0a;
    else if (bus.addr == OFFS[6'h0b]) hit_idx = 6'h0b;
    else if (bus.addr == OFFS[6'h0c]) hit_idx = 6'h0c;
    else if (bus.addr == OFFS[6'h0d]) hit_idx = 6'h0d;
    else if (bus.addr == OFFS[6'h0e]) hit_idx = 6'h0e;
    else if (bus.addr == OFFS[6'h0f]) hit_idx = 6'h0f;
    else if (bus.addr == OFFS[6'h10]) hit_idx = 6'h10;
    else if (bus.addr == OFFS[6'h11]) hit_idx = 6'h11;
    else if (bus.addr == OFFS[6'h12]) hit_idx = 6'h12;
    else if (bus.addr == OFFS[6'h13]) hit_idx = 6'h13;
    else if (bus.addr == OFFS[6'h14]) hit_idx = 6'h14;
    else if (bus.addr == OFFS[6'h15]) hit_idx = 6'h15;
    else if (bus.addr == OFFS[6'h16]) hit_idx = 6'h16;
    else if (bus.addr == OFFS[6'h17]) hit_idx = 6'h17;
    else if (bus.addr == OFFS[6'h18]) hit_idx = 6'h18;
    else if (bus.addr == OFFS[6'h19]) hit_idx = 6'h19;
    else if (bus.addr == OFFS[6'h1a]) hit_idx = 6'h1a;
    else if (bus.addr == OFFS[6'h1b]) hit_idx = 6'h1b;
    else if (bus.addr == OFFS[6'h1c]) hit_idx = 6'h1c;
    else if (bus.addr == OFFS[6'h1d]) hit_idx = 6'h1d;
    else if (bus.addr == OFFS[6'h1e]) hit_idx = 6'h1e;
    else if (bus.addr == OFFS[6'h1f]) hit_idx = 6'h1f;
    else if (bus.addr == OFFS[6'h20]) hit_idx = 6'h20;
    else if (bus.addr == OFFS[6'h21]) hit_idx = 6'h21;
    else if (bus.addr == OFFS[6'h22]) hit_idx = 6'h22;
    else if (bus.addr == OFFS[6'h23]) hit_idx = 6'h23;
    else if (bus.addr == OFFS[6'h24]) hit_idx = 6'h24;
    else if (bus.addr == OFFS[6'h25]) hit_idx = 6'h25;
    else if (bus.addr == OFFS[6'h26]) hit_idx = 6'h26;
    else if (bus.addr == OFFS[6'h27]) hit_idx = 6'h27;
    else if (bus.addr == OFFS[6'h28]) hit_idx = 6'h28;
    else if (bus.addr == OFFS[6'h29]) hit_idx = 6'h29;
    else if (bus.addr == OFFS[6'h2a]) hit_idx = 6'h2a;
    else if (bus.addr == OFFS[6'h2b]) hit_idx = 6'h2b;
    else if (bus.addr == OFFS[6'h2c]) hit_idx = 6'h2c;
    else hit = 1'b0;
  end

  // One mux per pin
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      pin_route_mux u_mux (
        .sel         (cur.sel[g]),
        .src         (src),
        .fixed_level (fixed_out[g]),
        .analog      (pin_analog_select_bit[g]),
        .dir_in      (pin_direction_bit[g]),
        .open_drain  (pin_open_drain_bit[g]),
        .level       (mux_level[g]),
        .drive_en    (mux_drive[g]),
        .routed      (mux_routed[g]),
        .bad         (mux_bad[g])
      );
    end
  endgenerate

  // Next state: register access and registered pad outputs.
  // Pads follow the mux one cycle late, so a new code shows on the
  // pin the cycle after the answer; the extra flop keeps every pad
  // output free of glitches while a selector or a source changes.
  always_comb begin
    next_state          = cur;
    next_state.ack      = 1'b0;
    next_state.level    = mux_level;
    next_state.drive_en = mux_drive;
    next_state.routed   = mux_routed;
    next_state.bad      = mux_bad;
    if (bus.req) begin
      // Answer one cycle after the request, with the old value
      next_state.ack = 1'b1;
      next_state.err = !hit;
      if (hit) begin
        next_state.rdata = {4'h0, cur.sel[hit_idx]};
      end else begin
        next_state.rdata = 8'h00;
      end
      // Only the low field is stored, so the top nibble ignores writes
      if (bus.we && hit) begin
        next_state.sel[hit_idx] = bus.wdata[`ROUTE_SEL_W-1:0];
      end
    end
  end

  // State register; pads reset low and undriven, then follow the fixed function from the first edge
  // The answer fields clear too, so a link read right after reset
  // sees no stale error from before it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur          <= '0;
      cur.sel      <= {N{`ROUTE_SEL_RESET}};
    end else begin
      cur <= next_state;
    end
  end

  // Outputs straight from the state register
  // Nothing here is combinational, so pads and link only ever see
  // values that settled at the last edge
  assign bus.ack      = cur.ack;
  assign bus.err      = cur.err;
  assign bus.rdata    = cur.rdata;
  assign pad_level    = cur.level;
  assign pad_drive_en = cur.drive_en;
  assign pin_routed   = cur.routed;
  assign pin_bad_code = cur.bad;

endmodule

// File: route_ctrl.sv
// AXI4-Lite controller that issues selector accesses on the link
`timescale 1ns/1ps
`include "route_defs.svh"
module route_ctrl (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Register access link
  route_if.ctrl                    bus,
  // AXI4-Lite write address and data
  input  wire logic [`CTRL_AW-1:0] awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  // AXI4-Lite write response
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  // AXI4-Lite read
  input  wire logic [`CTRL_AW-1:0] araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready
);
  import route_pkg::*;

  ctrl_state_t cur;
  ctrl_state_t next_state;
  logic        busy;

  assign busy = (cur.link == LINK_WAIT);

  // Bus slave and link sequencing
  always_comb begin
    next_state     = cur;
    next_state.req = 1'b0;
    // Address and data may arrive in either order
    if (awvalid && cur.awready) begin
      next_state.aw_held = 1'b1;
      next_state.awaddr  = awaddr;
    end
    if (wvalid && cur.wready) begin
      next_state.w_held = 1'b1;
      next_state.wd     = wdata;
      next_state.wstrb  = wstrb;
    end
    if (cur.aw_held && cur.w_held && !cur.bvalid) begin
      next_state.bvalid  = 1'b1;
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      if (cur.awaddr == `CTRL_CMD_OFF) begin
        next_state.bresp = `RESP_OKAY;
        // A command while busy or with any of lanes 0 to 2 unstrobed is dropped
        if (!busy && (&cur.wstrb[2:0])) begin
          next_state.req   = 1'b1;
          next_state.link  = LINK_WAIT;
          next_state.we    = cur.wd[`CMD_WE_BIT];
          next_state.addr  = cur.wd[`CMD_OFF_LSB +: `ROUTE_OFF_W];
          next_state.wdata = cur.wd[`CMD_DATA_LSB +: `ROUTE_REG_W];
          next_state.done  = 1'b0;
          next_state.err   = 1'b0;
        end
      end else if (cur.awaddr == `CTRL_STAT_OFF) begin
        next_state.bresp = `RESP_OKAY;
      end else begin
        next_state.bresp = `RESP_SLVERR;
      end
    end
    if (cur.bvalid && bready) begin
      next_state.bvalid = 1'b0;
    end
    next_state.awready = !next_state.aw_held && !next_state.bvalid;
    next_state.wready  = !next_state.w_held && !next_state.bvalid;
    // Read channel
    if (arvalid && cur.arready) begin
      next_state.rvalid   = 1'b1;
      next_state.rdata_ax = 32'h0000_0000;
      next_state.rresp    = `RESP_OKAY;
      if (araddr == `CTRL_CMD_OFF) begin
        next_state.rdata_ax[`CMD_WE_BIT]                    = cur.we;
        next_state.rdata_ax[`CMD_OFF_LSB +: `ROUTE_OFF_W]   = cur.addr;
        next_state.rdata_ax[`CMD_DATA_LSB +: `ROUTE_REG_W]  = cur.wdata;
      end else if (araddr == `CTRL_STAT_OFF) begin
        next_state.rdata_ax[`ST_BUSY_BIT]                   = busy;
        next_state.rdata_ax[`ST_DONE_BIT]                   = cur.done;
        next_state.rdata_ax[`ST_ERR_BIT]                    = cur.err;
        next_state.rdata_ax[`ST_DATA_LSB +: `ROUTE_REG_W]   = cur.rdata;
      end else begin
        next_state.rresp = `RESP_SLVERR;
      end
    end
    if (cur.rvalid && rready) begin
      next_state.rvalid = 1'b0;
    end
    next_state.arready = !next_state.rvalid;
    // Link: wait for the device answer
    case (cur.link)
      LINK_IDLE: begin
      end
      LINK_WAIT: begin
        if (bus.ack) begin
          next_state.link  = LINK_IDLE;
          next_state.done  = 1'b1;
          next_state.err   = bus.err;
          next_state.rdata = bus.rdata;
        end
      end
      default: begin
        next_state.link = LINK_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur         <= '0;
      cur.link    <= LINK_IDLE;
      cur.awready <= 1'b1;
      cur.wready  <= 1'b1;
      cur.arready <= 1'b1;
    end else begin
      cur <= next_state;
    end
  end

  // Outputs straight from the state register
  assign bus.req   = cur.req;
  assign bus.we    = cur.we;
  assign bus.addr  = cur.addr;
  assign bus.wdata = cur.wdata;
  assign awready   = cur.awready;
  assign wready    = cur.wready;
  assign bvalid    = cur.bvalid;
  assign bresp     = cur.bresp;
  assign arready   = cur.arready;
  assign rvalid    = cur.rvalid;
  assign rdata     = cur.rdata_ax;
  assign rresp     = cur.rresp;

endmodule

// File: route_properties.sv
// Link protocol and selector storage checks
`timescale 1ns/1ps
`include "route_defs.svh"
module route_properties (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Link signals
  input wire logic       req,
  input wire logic       we,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic       err,
  input wire logic [7:0] rdata
);
  logic [3:0] sh [128];
  logic       p_we;
  logic [6:0] p_a;
  logic [3:0] p_d;

  // True when the offset holds a selector
  function automatic logic mapped(input logic [6:0] a);
    logic [`ROUTE_NUM_PINS-1:0][6:0] t;
    t = `ROUTE_OFFSETS;
    mapped = 1'b0;
    for (int k = 0; k < `ROUTE_NUM_PINS; k++) begin
      if (t[k] == a) mapped = 1'b1;
    end
  endfunction

  // Shadow store; updated at ack so a read still sees the old code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p_we <= 1'b0;
      p_a  <= 7'h00;
      p_d  <= 4'h0;
      for (int k = 0; k < 128; k++) sh[k] <= 4'h0;
    end else begin
      if (req) begin
        p_we <= we;
        p_a  <= addr;
        p_d  <= wdata[3:0];
      end
      if (ack && p_we && mapped(p_a)) sh[p_a] <= p_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ack_timing_a: assert property (req |=> ack)
    else $error("ack not one cycle after req");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack |-> $past(req))
    else $error("ack without request");
  req_single_a: assert property (req |=> !req)
    else $error("request not a single pulse");
  map_err_a: assert property (ack |-> err == !mapped(p_a))
    else $error("err does not match offset map");
  err_zero_a: assert property (ack && err |-> rdata == 8'h00)
    else $error("refused access returned data");
  upper_zero_a: assert property (ack |-> rdata[7:4] == 4'h0)
    else $error("upper selector bits not zero");
  read_back_a: assert property (ack && !err |-> rdata[3:0] == sh[p_a])
    else $error("selector data differs from stored code");
  err_hold_a: assert property (!ack |-> $stable(err) && $stable(rdata))
    else $error("answer changed between acks");

  cover property (ack && !err && p_we);
  cover property (ack && !err && !p_we);
  cover property (ack && err);
endmodule

// File: port_output_function_router_bench.sv
// Self-checking bench for the controller and routing device pair
`timescale 1ns/1ps
`include "route_defs.svh"
module port_output_function_router_bench;
  import route_pkg::*;
  localparam int N = `ROUTE_NUM_PINS;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [7:0]        awaddr = 8'h00;
  logic [7:0]        araddr = 8'h00;
  logic [31:0]       wdata = 32'h0;
  logic [3:0]        wstrb = 4'hf;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [9:0]        src = 10'h000;
  logic [N-1:0]      analog = '0;
  logic [N-1:0]      dir = '0;
  logic [N-1:0]      od = '0;
  logic [N-1:0]      fixed = 45'h15a5a5a5a5a;
  logic [N-1:0]      pad_level, pad_drive_en, pin_routed, pin_bad_code;
  logic [3:0]        shadow [N];
  logic [N-1:0][6:0] offs = `ROUTE_OFFSETS;
  int                miscompares = 0;
  int                n_compared = 0;

  route_if link ();
  route_ctrl route_ctrl_i (.clk, .rst_n, .bus(link), .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  route_device route_device_i (.clk, .rst_n, .bus(link),
    .timer1_channel0_out(src[0]), .timer1_channel1_out(src[1]),
    .timer1_channel2_out(src[2]), .timer1_channel3_out(src[3]),
    .serial_ch0_data_out(src[4]), .serial_ch2_data_out(src[5]),
    .buzzer_clock_zero_out(src[6]), .serial_ch0_clock_out(src[7]),
    .serial_ch2_clock_out(src[8]), .uart_one_transmit(src[9]),
    .pin_analog_select_bit(analog), .pin_direction_bit(dir),
    .pin_open_drain_bit(od), .fixed_out(fixed), .pad_level, .pad_drive_en,
    .pin_routed, .pin_bad_code);
  route_properties route_properties_i (.clk, .rst_n, .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .err(link.err),
    .rdata(link.rdata));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic hang();
    miscompares++;
    tally_and_finish();
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // AXI write; the leading edge keeps drives of back-to-back calls apart
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 40) hang();
    chk("bresp", bresp, er);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (rvalid) break;
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (n == 40) hang();
    d = rdata;
    r = rresp;
  endtask

  // One selector access through the command and status registers
  task automatic acc(input logic w, input logic [6:0] o, input logic [7:0] d,
                     output logic [7:0] q, output logic e);
    logic [31:0] s;
    logic [1:0]  r;
    int          n;
    axw(8'h00, {15'h0, w, 1'b0, o, d}, `RESP_OKAY);
    for (n = 0; n < 20; n++) begin
      axr(8'h04, s, r);
      if (s[1]) break;
    end
    if (n == 20) hang();
    chk("st_resp", r, `RESP_OKAY);
    q = s[15:8];
    e = s[2];
  endtask

  // Pad outputs against the bench's own model of every pin
  task automatic pads();
    logic [N-1:0] lv, de, ro, bd;
    logic [3:0]   s;
    repeat (2) @(posedge clk);
    for (int i = 0; i < N; i++) begin
      s = shadow[i];
      ro[i] = s inside {[1:10]};
      bd[i] = s > 4'ha;
      lv[i] = analog[i] ? 1'b0 : ro[i] ? src[s-1] : fixed[i];
      de[i] = !analog[i] && !dir[i] && (!od[i] || !lv[i]);
    end
    chk("pad_level", pad_level, lv);
    chk("pad_drive_en", pad_drive_en, de);
    chk("pin_routed", pin_routed, ro);
    chk("pin_bad_code", pin_bad_code, bd);
  endtask

  task automatic t_reset();
    logic [7:0] q;
    logic       e;
    for (int i = 0; i < N; i++) begin
      shadow[i] = 4'h0;
      acc(1'b0, offs[i], 8'h00, q, e);
      chk("reset_sel", {e, q}, 9'h000);
    end
    pads();
  endtask

  // Each of codes one to ten lands on its own pin; two source patterns per code
  task automatic t_codes();
    logic [7:0] q;
    logic       e;
    for (int c = 1; c <= 10; c++) begin
      acc(1'b1, offs[c*4], 8'(c), q, e);
      chk("old_sel", {e, q}, 9'h000);
      acc(1'b0, offs[c*4], 8'h00, q, e);
      chk("new_sel", {e, q}, 9'(c));
      shadow[c*4] = 4'(c);
      src <= 10'h2a5;
      pads();
      src <= 10'h15a;
      pads();
    end
  endtask

  task automatic t_bad();
    logic [7:0] q;
    logic       e;
    for (int c = 11; c <= 15; c++) begin
      acc(1'b1, offs[1], 8'(c), q, e);
      acc(1'b0, offs[1], 8'h00, q, e);
      chk("bad_sel", {e, q}, 9'(c));
      shadow[1] = 4'(c);
      pads();
    end
    acc(1'b1, offs[1], 8'hf3, q, e);
    acc(1'b0, offs[1], 8'h00, q, e);
    chk("upper_bits", {e, q}, 9'h003);
    shadow[1] = 4'h3;
    pads();
  endtask

  task automatic t_err();
    logic [7:0]  q;
    logic        e;
    logic [31:0] s;
    logic [1:0]  r;
    acc(1'b1, 7'h02, 8'h05, q, e);
    chk("hole_write", {e, q}, 9'h100);
    acc(1'b0, 7'h58, 8'h00, q, e);
    chk("past_end", {e, q}, 9'h100);
    axr(8'h00, s, r);
    chk("cmd_back", s, 32'h0000_5800);
    // Partial lanes drop the command, so the selector stays clear
    wstrb <= 4'h1;
    axw(8'h00, {15'h0, 1'b1, 1'b0, offs[2], 8'h07}, `RESP_OKAY);
    wstrb <= 4'hf;
    acc(1'b0, offs[2], 8'h00, q, e);
    chk("part_lanes", {e, q}, 9'h000);
    axw(8'h04, 32'h0, `RESP_OKAY);
    axw(8'h08, 32'h0, `RESP_SLVERR);
    axr(8'h10, s, r);
    chk("rd_resp", {r, s}, {`RESP_SLVERR, 32'h0});
  endtask

  // Pin mode bits around a routed timer output, then a mid-run reset
  task automatic t_modes();
    logic [7:0] q;
    logic       e;
    src <= 10'h001;
    analog[4] <= 1'b1;
    pads();
    analog[4] <= 1'b0;
    dir[4] <= 1'b1;
    pads();
    dir[4] <= 1'b0;
    od <= {N{1'b1}};
    pads();
    src <= 10'h000;
    pads();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (shadow[i]) shadow[i] = 4'h0;
    acc(1'b0, offs[4], 8'h00, q, e);
    chk("rerun_sel", {e, q}, 9'h000);
    pads();
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_codes();
    t_bad();
    t_err();
    t_modes();
    tally_and_finish();
  end
endmodule
